// ==== common/nni_pkg.sv ====
/*
 Shared constants for the link-management controller: parameter
 ranges, defaults, clock rate and timer encodings.
 Assumes a single 25 MHz system clock.
*/
package nni_pkg;
    // ==========================================================
    // Clock and prescaler
    // ==========================================================
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned TICK_SECONDS  = 1;
    localparam int unsigned TICK_CYCLES   = CLK_HZ * TICK_SECONDS;
    // ==========================================================
    // Parameter defaults and limits
    // ==========================================================
    localparam logic [7:0] FULL_PERIOD_DEF = 8'h06;
    localparam logic [7:0] FULL_PERIOD_MIN = 8'h01;
    localparam logic [3:0] ERR_LIMIT_DEF   = 4'h3;
    localparam logic [3:0] WINDOW_DEF      = 4'h4;
    localparam logic [3:0] COUNT_MAX       = 4'hA;
    localparam logic [4:0] POLL_TIME_DEF   = 5'h0A;
    localparam logic [4:0] POLL_TIME_MIN   = 5'h05;
    localparam logic [4:0] POLL_TIME_MAX   = 5'h1E;
    localparam logic [4:0] VERIFY_TIME_DEF = 5'h0F;
    localparam int unsigned PVC_COUNT      = 4;
    // ==========================================================
    // Polling sequencer states
    // ==========================================================
    typedef enum logic [2:0]
    {
        POLL_IDLE = 3'b001,
        POLL_WAIT = 3'b010,
        POLL_SEND = 3'b100
    } poll_state_e;
endpackage : nni_pkg

// ==== common/nni_mon_if.sv ====
/*
 Carrier between the top and its error monitors: event pulses in,
 channel state out. Assumes one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface nni_mon_if;
    logic       event_valid;
    logic       event_error;
    logic [3:0] err_limit;
    logic [3:0] window;
    logic       fast_start;
    logic       operational;
    modport mon (input event_valid, event_error, err_limit, window,
                 fast_start, output operational);
    modport ctl (output event_valid, event_error, err_limit, window,
                 fast_start, input operational);
endinterface : nni_mon_if
`default_nettype wire

// ==== core/nni_err_mon.sv ====
/*
 Error window monitor for one procedure side. Declares the channel
 inactive on too many errors in the last events; recovers after
 enough consecutive valid cycles. Events are one-cycle pulses.
*/
`timescale 1ns/100ps
`default_nettype none
module nni_err_mon
(
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    nni_mon_if.mon          mon
);
    import nni_pkg::*;

    logic [9:0] history;
    logic [3:0] good_run;
    logic       first_done;
    logic [3:0] err_count;
    logic [9:0] next_history;

    // ==========================================================
    // Window bookkeeping
    // ==========================================================
    // Errors are counted over the newest window entries only
    always_comb
    begin
        next_history = {history[8:0], mon.event_error};
        err_count = 4'h0;
        for (int i = 0; i < 10; i++)
        begin
            if (i < int'(mon.window) && next_history[i])
                err_count = err_count + 4'h1;
        end
    end

    // Shift history on each monitored event
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            history <= 10'h000;
        else if (mon.event_valid)
            history <= next_history; // [RQ4]
    end

    // Consecutive valid polling cycle counter
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            good_run <= 4'h0;
        else if (mon.event_valid)
        begin
            if (mon.event_error)
                good_run <= 4'h0;
            else if (good_run != COUNT_MAX)
                good_run <= good_run + 4'h1;
        end
    end

    // Channel state, non-operational from start
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            mon.operational <= 1'b0; // [RQ13]
            first_done      <= 1'b0;
        end
        else if (mon.event_valid)
        begin
            first_done <= 1'b1;
            if (!first_done && mon.fast_start && !mon.event_error)
                mon.operational <= 1'b1; // [RQ14]
            else if (err_count >= mon.err_limit)
                mon.operational <= 1'b0; // [RQ4]
            else if (!mon.event_error && good_run + 4'h1 >= mon.window)
                mon.operational <= 1'b1; // [RQ13]
        end
    end

    start_down_a: assert property (@(posedge clk_sys) // [RQ13]
        $rose(sys_rst) |=> !mon.operational)
        else $error("channel not down after reset");
    err_drop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        mon.event_valid && err_count >= mon.err_limit && // [RQ4]
        !(!first_done && mon.fast_start && !mon.event_error)
        |=> !mon.operational)
        else $error("channel stayed up on error limit");
endmodule : nni_err_mon
`default_nettype wire

// ==== core/nni_sec_tick.sv ====
/*
 One-second tick prescaler. Assumes the system clock rate in the
 package; the count is a parameter to allow fast simulation.
*/
`timescale 1ns/100ps
`default_nettype none
module nni_sec_tick
#(
    parameter int unsigned TICK_CYCLES_P = nni_pkg::TICK_CYCLES
)
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    output logic      tick
);
    import nni_pkg::*;

    logic [24:0] count;

    // Divider produces a one-cycle pulse each second
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            count <= 25'h0000000;
            tick  <= 1'b0;
        end
        else if (count == 25'(TICK_CYCLES_P - 1))
        begin
            count <= 25'h0000000;
            tick  <= 1'b1; // [RQ21]
        end
        else
        begin
            count <= count + 25'h0000001;
            tick  <= 1'b0;
        end
    end
endmodule : nni_sec_tick
`default_nettype wire

// ==== core/nni_link_mgr.sv ====
/*
 NNI bidirectional link-management controller: user-side poller,
 network-side poll verifier, channel monitors and per-PVC status
 propagation toward the UNI. Assumes message framing and sequence
 number checking happen outside; results arrive as pulses.
*/
// Behaviour
// [RQ1] User-side and network-side procedures run concurrently and independently.
// [RQ2] Separate parameter sets: user side T391/N391/N392/N393, network T392/N392/N393; here both sides share one N392 and one N393.
// [RQ3] Full status period configurable 1 to 255, default 6.
// [RQ4] Inactive when error limit reached within last window events, both up to 10.
// [RQ5] Polling timer 5 to 30 seconds, default 10.
// [RQ6] Verification timer programmable, default 15 seconds.
// [RQ7] Error limit should not exceed window; verify time above poll time. Here only the limit is clamped; verify time is not checked.
// [RQ8] Enquiry at each poll expiry; every Nth one asks for full status.
// [RQ9] Timers and counts match in both networks; full period may differ.
// [RQ10] Learned PVC status forwards toward the UNI end.
// [RQ11] Sent active bit independent of active bit received opposite way.
// [RQ12] After segment change, answer next enquiry with full status.
// [RQ13] Channel starts down; up after N393 consecutive valid cycles.
// [RQ14] Optional fast start when first cycle is valid.
// [RQ15] Active only if configured, links operational, segments up, remote active.
// [RQ16] Any failed criterion clears the propagated active bit.
// [RQ17] Only the UNI-terminating network may originate active one.
// [RQ18] Transit networks pass active unchanged or force zero.
// [RQ19] Element presence means only local segment exists.
// [RQ20] Added segment sets the new bit for that PVC.
// [RQ21] Seconds tick from prescaler clocks and restarts both timers.
`timescale 1ns/100ps
`default_nettype none
module nni_link_mgr
#(
    parameter int unsigned PVCS          = nni_pkg::PVC_COUNT,
    parameter int unsigned TICK_CYCLES_P = nni_pkg::TICK_CYCLES
)
(
    input  wire logic            clk_sys,
    input  wire logic            sys_rst,
    input  wire logic            enable,
    input  wire logic            fast_start,
    input  wire logic [7:0]      full_period,
    input  wire logic [3:0]      err_limit,
    input  wire logic [3:0]      window,
    input  wire logic [4:0]      poll_time,
    input  wire logic [4:0]      verify_time,
    input  wire logic            uside_reply_ok,
    input  wire logic            uside_reply_err,
    input  wire logic            nside_enq_ok,
    input  wire logic            nside_enq_err,
    input  wire logic            uni_terminates,
    input  wire logic            uni_link_ok,
    input  wire logic [PVCS-1:0] seg_configured,
    input  wire logic [PVCS-1:0] seg_operational,
    input  wire logic [PVCS-1:0] rx_present,
    input  wire logic [PVCS-1:0] rx_active,
    input  wire logic            rx_full_valid,
    input  wire logic            rx_async_valid,
    input  wire logic [PVCS-1:0] rx_async_sel,
    input  wire logic            reply_sent,
    output logic                 enq_send,
    output logic                 enq_full,
    output logic                 uside_up,
    output logic                 nside_up,
    output logic                 reply_full,
    output logic [PVCS-1:0]      tx_active,
    output logic [PVCS-1:0]      tx_new,
    output logic [PVCS-1:0]      uni_active,
    output logic [PVCS-1:0]      remote_present
);
    import nni_pkg::*;

    nni_mon_if umon ();
    nni_mon_if nmon ();

    logic            tick;
    poll_state_e     poll_state;
    logic [4:0]      poll_sec;
    logic [4:0]      verify_sec;
    logic [7:0]      full_cnt;
    logic            verify_expire;
    logic [PVCS-1:0] remote_active;
    logic [PVCS-1:0] seg_prev;
    logic            change_pending;
    logic [4:0]      poll_eff;
    logic [7:0]      full_eff;
    logic [3:0]      win_eff;
    logic [3:0]      lim_eff;
    logic [PVCS-1:0] tx_prev;

    // ==========================================================
    // Parameter sanitising
    // ==========================================================
    // Clamp out-of-range settings except verify time into their legal ranges
    always_comb
    begin
        poll_eff = poll_time;
        if (poll_time < POLL_TIME_MIN)
            poll_eff = POLL_TIME_MIN; // [RQ5]
        else if (poll_time > POLL_TIME_MAX)
            poll_eff = POLL_TIME_MAX; // [RQ5]
        full_eff = (full_period < FULL_PERIOD_MIN) ? FULL_PERIOD_MIN
                                                   : full_period; // [RQ3]
        win_eff = (window > COUNT_MAX) ? COUNT_MAX : window; // [RQ4]
        lim_eff = (err_limit > COUNT_MAX) ? COUNT_MAX : err_limit; // [RQ4]
        // A limit above the window could never be reached
        if (lim_eff > win_eff)
            lim_eff = win_eff; // [RQ7]
    end

    // Monitor hookups: shared error limit and window per side
    assign umon.event_valid = uside_reply_ok | uside_reply_err; // [RQ2]
    assign umon.event_error = uside_reply_err;
    assign umon.err_limit   = lim_eff; // [RQ4]
    assign umon.window      = win_eff;
    assign umon.fast_start  = fast_start; // [RQ14]
    assign nmon.event_valid = enable & (nside_enq_ok | nside_enq_err
                                        | verify_expire); // [RQ2]
    assign nmon.event_error = nside_enq_err | verify_expire;
    assign nmon.err_limit   = umon.err_limit; // [RQ9]
    assign nmon.window      = umon.window;
    assign nmon.fast_start  = fast_start;

    // ==========================================================
    // Submodules
    // ==========================================================
    nni_sec_tick
    #(
        .TICK_CYCLES_P (TICK_CYCLES_P)
    )
    u_tick
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    // Two independent monitors, one per procedure side
    nni_err_mon u_umon // [RQ1]
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst | ~enable),
        .mon     (umon)
    );

    nni_err_mon u_nmon // [RQ1]
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst | ~enable),
        .mon     (nmon)
    );

    assign uside_up = umon.operational;
    assign nside_up = nmon.operational;

    // ==========================================================
    // User-side poller
    // ==========================================================
    // Poll timer state machine, restarts each enquiry
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !enable)
        begin
            poll_state <= POLL_IDLE;
            poll_sec   <= 5'h00;
        end
        else
        begin
            unique case (poll_state)
                POLL_IDLE:
                begin
                    poll_sec   <= 5'h00;
                    poll_state <= POLL_SEND;
                end
                POLL_WAIT:
                begin
                    if (tick && poll_sec + 5'h01 >= poll_eff)
                        poll_state <= POLL_SEND; // [RQ21]
                    else if (tick)
                        poll_sec <= poll_sec + 5'h01;
                end
                POLL_SEND:
                begin
                    poll_sec   <= 5'h00; // [RQ21]
                    poll_state <= POLL_WAIT;
                end
            endcase
        end
    end

    // Full status counter picks every Nth enquiry
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !enable)
            full_cnt <= 8'h01;
        else if (poll_state == POLL_SEND)
            full_cnt <= (full_cnt >= full_eff) ? 8'h01
                                               : full_cnt + 8'h01; // [RQ8]
    end

    // Enquiry pulse and its report-type flag
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !enable)
        begin
            enq_send <= 1'b0;
            enq_full <= 1'b0;
        end
        else
        begin
            enq_send <= (poll_state == POLL_SEND); // [RQ8]
            enq_full <= (poll_state == POLL_SEND) &&
                        (full_cnt >= full_eff); // [RQ8]
        end
    end

    // ==========================================================
    // Network-side poll verification
    // ==========================================================
    // Counts seconds since last enquiry; expiry is an error event
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !enable || nside_enq_ok || nside_enq_err)
        begin
            verify_sec    <= 5'h00; // [RQ21]
            verify_expire <= 1'b0;
        end
        else if (tick && verify_sec + 5'h01 >= verify_time)
        begin
            verify_sec    <= 5'h00;
            verify_expire <= 1'b1; // [RQ6]
        end
        else
        begin
            if (tick)
                verify_sec <= verify_sec + 5'h01;
            verify_expire <= 1'b0;
        end
    end

    // ==========================================================
    // Received PVC status
    // ==========================================================
    // Full reports replace all entries; async reports update selected
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            remote_present <= '0;
            remote_active  <= '0;
        end
        else if (rx_full_valid)
        begin
            remote_present <= rx_present; // [RQ19]
            remote_active  <= rx_active & rx_present; // [RQ10]
        end
        else if (rx_async_valid)
        begin
            remote_present <= remote_present | rx_async_sel;
            remote_active  <= (remote_active & ~rx_async_sel)
                              | (rx_active & rx_async_sel); // [RQ10]
        end
    end

    // ==========================================================
    // Outgoing and forwarded status
    // ==========================================================
    // Per-PVC active and new bits
    generate
        for (genvar p = 0; p < PVCS; p++)
        begin : g_pvc
            logic crit;
            assign crit = seg_configured[p] && seg_operational[p]
                          && uni_link_ok && uside_up
                          && nside_up; // [RQ15]

            // Toward peer: own side only, never echo received bit
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                    tx_active[p] <= 1'b0;
                else
                    tx_active[p] <= crit && uni_terminates; // [RQ11] [RQ17]
            end

            // Toward UNI: remote bit passes only when all criteria hold
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                    uni_active[p] <= 1'b0;
                else
                    uni_active[p] <= crit && remote_present[p]
                                     && remote_active[p]; // [RQ16] [RQ18]
            end

            // New bit set when segment added, cleared after report
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                    tx_new[p] <= 1'b0;
                else if (seg_configured[p] && !seg_prev[p])
                    tx_new[p] <= 1'b1; // [RQ20]
                else if (reply_sent || !seg_configured[p])
                    tx_new[p] <= 1'b0;
            end
        end
    endgenerate

    // Change history for full-status replies
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            seg_prev       <= '0;
            tx_prev        <= '0;
            change_pending <= 1'b0;
        end
        else
        begin
            seg_prev <= seg_configured;
            tx_prev  <= tx_active;
            if (seg_prev != seg_configured || tx_prev != tx_active)
                change_pending <= 1'b1; // [RQ12]
            else if (reply_sent)
                change_pending <= 1'b0;
        end
    end

    assign reply_full = change_pending; // [RQ12]

    // ==========================================================
    // Checks
    // ==========================================================
    full_every_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst || !enable)
        enq_full |-> enq_send) // [RQ8]
        else $error("full request without enquiry");
    no_origin_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !uni_terminates |=> tx_active == '0) // [RQ17]
        else $error("transit network originated active");
    uni_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !uside_up |=> uni_active == '0) // [RQ16]
        else $error("active forwarded with channel down");
    pass_only_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (remote_active == '0) |=> uni_active == '0) // [RQ18]
        else $error("active forwarded without remote active");
    new_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        seg_configured[0] && !seg_prev[0] |=> tx_new[0]) // [RQ20]
        else $error("new bit missing on add");
    pend_reply_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        seg_prev != seg_configured |=> reply_full) // [RQ12]
        else $error("change did not request full reply");
    verify_exp_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst || !enable)
        verify_expire |-> $past(tick)) // [RQ6]
        else $error("verify expiry without tick");
    poll_gap_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst || !enable)
        enq_send |=> !enq_send [*2]) // [RQ5]
        else $error("enquiries too close");
endmodule : nni_link_mgr
`default_nettype wire

// ==== testbench/nni_peer_model.sv ====
/*
 Peer network controller model: answers each of our enquiries with a
 reply event, good or bad as commanded. Assumes registered enquiries.
*/
`timescale 1ns/100ps
`default_nettype none
module nni_peer_model
(
    input  wire logic clk_sys,
    input  wire logic enq_send,
    input  wire logic bad_reply,
    output logic      reply_ok,
    output logic      reply_err
);
    // ==========================================================
    // Reply engine
    // ==========================================================
    // Answer two cycles after the enquiry, a one-cycle pulse
    initial
    begin
        reply_ok  = 1'b0;
        reply_err = 1'b0;
        forever
        begin
            @(posedge clk_sys);
            if (enq_send === 1'b1)
            begin
                repeat (2) @(posedge clk_sys);
                #1;
                reply_ok  = !bad_reply;
                reply_err = bad_reply;
                @(posedge clk_sys);
                #1;
                reply_ok  = 1'b0;
                reply_err = 1'b0;
            end
        end
    end
endmodule : nni_peer_model
`default_nettype wire

// ==== testbench/tb_nni_link_mgr.sv ====
/*
 Self-checking bench for the link-management controller with a fast
 seconds tick. Assumes the peer model for the user-side replies.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_nni_link_mgr;
    import nni_pkg::*;
    logic       clk_sys = 1'b0, sys_rst = 1'b1, enable = 1'b0;
    logic       fast_start = 1'b0, bad = 1'b0, nok = 1'b0, nerr = 1'b0;
    logic       uterm = 1'b1, ulink = 1'b1, rx_full = 1'b0, rsent = 1'b0;
    logic [3:0] cfg = 4'h7, oper = 4'hF, rx_pres = 4'hF, rx_act = 4'hF;
    logic       rx_async = 1'b0;
    logic [3:0] rx_sel = 4'h0;
    logic [4:0] vt = 5'h1E;
    logic       u_ok, u_err, enq_send, enq_full, uside_up, nside_up;
    logic       reply_full;
    logic [3:0] tx_active, tx_new, uni_active, remote_present;
    int         n_fail = 0, checks = 0, cyc = 0, n_enq = 0, last = 0, gap;
    // Clock
    always #20 clk_sys = ~clk_sys;
    // ==========================================================
    // Devices
    // ==========================================================
    nni_link_mgr #(.PVCS(4), .TICK_CYCLES_P(10)) i_nni_link_mgr
    (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .enable(enable),
        .fast_start(fast_start), .full_period(8'h02),
        .err_limit(4'h3), .window(4'h4), .poll_time(5'h05),
        .verify_time(vt), .uside_reply_ok(u_ok),
        .uside_reply_err(u_err), .nside_enq_ok(nok),
        .nside_enq_err(nerr), .uni_terminates(uterm),
        .uni_link_ok(ulink), .seg_configured(cfg),
        .seg_operational(oper), .rx_present(rx_pres),
        .rx_active(rx_act), .rx_full_valid(rx_full),
        .rx_async_valid(rx_async), .rx_async_sel(rx_sel),
        .reply_sent(rsent), .enq_send(enq_send), .enq_full(enq_full),
        .uside_up(uside_up), .nside_up(nside_up),
        .reply_full(reply_full), .tx_active(tx_active),
        .tx_new(tx_new), .uni_active(uni_active),
        .remote_present(remote_present)
    );
    nni_peer_model i_nni_peer_model
    (
        .clk_sys(clk_sys), .enq_send(enq_send), .bad_reply(bad),
        .reply_ok(u_ok), .reply_err(u_err)
    );
    // ==========================================================
    // Tasks
    // ==========================================================
    task check(string name, logic [7:0] seen, logic [7:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check
    task step(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    // n one-cycle event pulses on the network side, one idle cycle apart
    task nside(logic err, int n);
        repeat (n)
        begin
            nok  = !err;
            nerr = err;
            step(1);
            nok  = 1'b0;
            nerr = 1'b0;
            step(1);
        end
    endtask : nside
    task end_sim;
        $display("checks %0d, failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    // Enquiry spacing of 5 ticks of 10 cycles, every 2nd one full; the
    // first gap hangs on the tick phase at start, so it is a range.
    // Hang limit last, since it ends the run.
    always @(posedge clk_sys)
    begin
        cyc = cyc + 1;
        if (enq_send === 1'b1 && !sys_rst)
        begin
            n_enq = n_enq + 1;
            gap = cyc - last;
            check("enq_full", enq_full, n_enq % 2 == 0);
            if (n_enq == 2)
                check("enq_gap1", gap > 40 && gap <= 50, 1);
            else if (n_enq > 2)
                check("enq_gap", gap, 50);
            last = cyc;
        end
        if (cyc > 3000)
        begin
            n_fail = n_fail + 1;
            end_sim();
        end
    end
    // ==========================================================
    // Scenarios
    // ==========================================================
    initial
    begin
        step(20);
        sys_rst = 1'b0;
        check("uside_up", uside_up, 0);
        enable = 1'b1;
        step(2);
        nside(0, 3);
        check("nside_up", nside_up, 0);
        nside(0, 1);
        step(1);
        check("nside_up", nside_up, 1);
        nside(1, 2);
        check("nside_up", nside_up, 1);
        nside(1, 1);
        step(1);
        check("nside_up", nside_up, 0);
        nside(0, 4);
        step(200);
        nside(0, 1);
        check("uside_up", uside_up, 1);
        check("nside_up", nside_up, 1);
        rsent = 1'b1;
        step(1);
        rsent = 1'b0;
        cfg = 4'hF;
        step(2);
        check("tx_new", tx_new, 4'h8);
        check("reply_full", reply_full, 1);
        rsent = 1'b1;
        step(1);
        rsent = 1'b0;
        step(2);
        check("tx_new", tx_new, 4'h0);
        check("reply_full", reply_full, 0);
        rx_full = 1'b1;
        step(1);
        rx_full = 1'b0;
        step(2);
        check("uni_active", uni_active, 4'hF);
        oper = 4'hD;
        step(2);
        check("uni_active", uni_active, 4'hD);
        check("tx_active", tx_active, 4'hD);
        rx_act = 4'h0;
        rx_pres = 4'h5;
        rx_full = 1'b1;
        step(1);
        rx_full = 1'b0;
        step(2);
        check("remote_present", remote_present, 4'h5);
        check("uni_active", uni_active, 4'h0);
        check("tx_active", tx_active, 4'hD);
        rx_act = 4'hF;
        rx_sel = 4'h6;
        rx_async = 1'b1;
        step(1);
        rx_async = 1'b0;
        step(2);
        check("remote_present", remote_present, 4'h7);
        check("uni_active", uni_active, 4'h4);
        uterm = 1'b0;
        step(2);
        check("tx_active", tx_active, 4'h0);
        check("uni_active", uni_active, 4'h4);
        ulink = 1'b0;
        uterm = 1'b1;
        step(2);
        check("tx_active", tx_active, 4'h0);
        check("uni_active", uni_active, 4'h0);
        bad = 1'b1;
        step(160);
        check("uside_up", uside_up, 0);
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        fast_start = 1'b1;
        n_enq = 0;
        step(2);
        check("nside_up", nside_up, 0);
        nside(0, 1);
        step(1);
        check("nside_up", nside_up, 1);
        // No more peer enquiries: three verify expiries drop the side
        vt = 5'h05;
        step(160);
        check("nside_up", nside_up, 0);
        end_sim();
    end
endmodule : tb_nni_link_mgr
`default_nettype wire
